// file: core/sgpc_age_timer.sv
`timescale 1ns/1ns
module sgpc_age_timer
  import sgpc_pkg::*;
#(
  parameter int unsigned     CNT_W      = AGE_CNT_W,
  parameter longint unsigned NORMAL_CYC = AGE_NORMAL_CYC_DFLT,
  parameter longint unsigned FAST_CYC   = FAST_AGE_CYC_DFLT
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic age_en,
  input  wire logic fast_age,
  input  wire logic trigger,
  output logic      age_tick,
  output logic      fast_active
);

  localparam logic [CNT_W-1:0] NORMAL_LIM = CNT_W'(NORMAL_CYC - 64'd1);
  localparam logic [CNT_W-1:0] FAST_LIM   = CNT_W'(FAST_CYC - 64'd1);

  if (NORMAL_CYC < 64'd1 || FAST_CYC < 64'd1 || (NORMAL_CYC >> CNT_W) != 64'd0) begin : g_bad
    $error("aging period does not fit the counter");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             pend;
    logic             tick;
  } sgpc_age_s;

  sgpc_age_s        s_q;
  sgpc_age_s        s_d;
  logic [CNT_W-1:0] lim_w;

  assign lim_w = (fast_age || s_q.pend) ? FAST_LIM : NORMAL_LIM;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!age_en) begin
      s_d.cnt  = '0;
      s_d.pend = 1'b0;
    end else begin
      if (s_q.cnt >= lim_w) begin
        s_d.cnt  = '0;
        s_d.tick = 1'b1;
        s_d.pend = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
      end
      // a new trigger wins over the pass that just ended
      if (trigger) begin
        s_d.pend = 1'b1;
        if (!s_q.pend) begin
          s_d.cnt = '0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{cnt: '0, pend: 1'b0, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign age_tick    = s_q.tick;
  assign fast_active = s_q.pend;

  property p_fast_done;
    @(posedge core_clk) disable iff (!resetn)
    (age_en && s_q.pend && s_q.cnt == FAST_LIM && !trigger) |=> (s_q.tick && !s_q.pend);
  endproperty
  a_fast_done: assert property (p_fast_done) else $error("fast pass did not end");

  property p_fast_period;
    @(posedge core_clk) disable iff (!resetn)
    (age_en && fast_age && s_q.cnt == FAST_LIM) |=> (s_q.tick && s_q.cnt == '0);
  endproperty
  a_fast_period: assert property (p_fast_period) else $error("fast period missed");

endmodule : sgpc_age_timer

// file: core/sgpc_apb_slave.sv
`timescale 1ns/1ns
module sgpc_apb_slave
  import sgpc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  sgpc_reg_if.bus                rif
);

  typedef struct packed {
    sgpc_apb_st_e st;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
  } sgpc_apb_s;

  sgpc_apb_s s_q;
  sgpc_apb_s s_d;
  logic      ok_w;

  assign rif.idx   = paddr[APB_AW-1:2];
  assign rif.wdata = pwdata[REG_W-1:0];
  // misaligned addresses are refused like unmapped ones
  assign ok_w      = rif.hit && (paddr[1:0] == 2'h0);

  // ----------------------------------------------------------------
  // one wait-free access phase; read data is latched in setup
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    rif.wr_en = 1'b0;
    case (s_q.st)
      APB_IDLE: begin
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.prdata  = 32'h0;
        if (psel && !penable) begin
          s_d.st      = APB_ACCESS;
          s_d.pready  = 1'b1;
          s_d.pslverr = !ok_w;
          s_d.prdata  = (pwrite || !ok_w) ? 32'h0 : {24'h0, rif.rdata};
        end
      end
      APB_ACCESS: begin
        rif.wr_en   = psel && penable && pwrite && ok_w;
        s_d.st      = APB_IDLE;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.prdata  = 32'h0;
      end
      default: begin
        s_d.st = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{st: APB_IDLE, pready: 1'b0, prdata: 32'h0, pslverr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;

endmodule : sgpc_apb_slave

// file: core/sgpc_global_policy_ctrl.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module sgpc_global_policy_ctrl
  import sgpc_pkg::*;
#(
  parameter int unsigned     NPORTS         = 5,
  parameter longint unsigned AGE_NORMAL_CYC = AGE_NORMAL_CYC_DFLT,
  parameter longint unsigned FAST_AGE_CYC   = FAST_AGE_CYC_DFLT
) (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              flow_control_strap_pin,
  input  wire logic              aging_strap_pin,
  input  wire logic              backoff_strap_pin,
  input  wire logic [NPORTS-1:0] port_link_up,
  input  wire logic [NPORTS-1:0] an_tx_pause,
  input  wire logic [NPORTS-1:0] an_rx_pause,
  input  wire logic              rx_valid,
  input  wire logic [15:0]       rx_type_len,
  input  wire logic [47:0]       rx_da,
  input  wire logic [15:0]       rx_len,
  input  wire logic              rx_is_pause,
  input  wire logic              rx_bad,
  output logic                   rx_result_valid,
  output logic                   rx_drop,
  output logic [NPORTS-1:0]      tx_fc_en,
  output logic [NPORTS-1:0]      rx_fc_en,
  output logic                   aggressive_backoff,
  output logic                   pass_all_frames,
  output logic                   age_tick,
  output logic                   fast_age_active,
  output logic                   table_flush
);

  if (NPORTS < 1 || NPORTS > 32) begin : g_bad
    $error("NPORTS out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [REG_W-1:0]  fwd;
    logic [REG_W-1:0]  mac;
    logic              strap_done;
    logic [NPORTS-1:0] link_prev;
    logic [NPORTS-1:0] tx_fc;
    logic [NPORTS-1:0] rx_fc;
    logic              res_valid;
    logic              drop;
    logic              flush;
  } sgpc_top_s;

  sgpc_top_s         s_q;
  sgpc_top_s         s_d;
  sgpc_reg_if        rif ();
  logic [NPORTS-1:0] fall_w;
  logic [NPORTS-1:0] tx_fc_w;
  logic [NPORTS-1:0] rx_fc_w;
  logic              any_fall_w;
  logic              fast_trig_w;
  logic              fc_hit_w;
  logic              len_bad_w;
  logic              drop_w;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  sgpc_apb_slave u_apb (
    .core_clk (core_clk),
    .resetn   (resetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .rif      (rif)
  );

  assign rif.hit   = (rif.idx == FWD_POL_IDX) || (rif.idx == MAC_POL_IDX);
  assign rif.rdata = (rif.idx == FWD_POL_IDX) ? s_q.fwd :
                     (rif.idx == MAC_POL_IDX) ? s_q.mac : 8'h00;

  // ----------------------------------------------------------------
  // per-port link loss and pause enables
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NPORTS; i++) begin : g_port
    assign fall_w[i]  = s_q.link_prev[i] && !port_link_up[i];
    assign tx_fc_w[i] = an_tx_pause[i] && !s_q.mac[MAC_TX_DIS_BIT];
    assign rx_fc_w[i] = an_rx_pause[i] && !s_q.mac[MAC_RX_DIS_BIT];
  end

  assign any_fall_w  = |fall_w;
  assign fast_trig_w = any_fall_w && s_q.fwd[FWD_LNK_AGE_BIT];

  // ----------------------------------------------------------------
  // frame filter
  // ----------------------------------------------------------------
  // the loose match also eats non-pause MAC control frames; that is intended
  assign fc_hit_w  = s_q.fwd[FWD_FC_SEL_BIT] ?
                     ((rx_type_len == PAUSE_TYPE) || (rx_da == PAUSE_DA)) :
                     rx_is_pause;
  assign len_bad_w = s_q.mac[MAC_LEN_CHK_BIT] && (rx_type_len < LEN_LIMIT) &&
                     (rx_type_len != rx_len);
  // debug pass-all overrides every drop reason
  assign drop_w    = !s_q.mac[MAC_PASS_BIT] && (fc_hit_w || len_bad_w || rx_bad);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.link_prev = port_link_up;
    s_d.tx_fc     = tx_fc_w;
    s_d.rx_fc     = rx_fc_w;
    s_d.res_valid = rx_valid;
    s_d.drop      = rx_valid && drop_w;
    s_d.flush     = any_fall_w && s_q.mac[MAC_AGE_EN_BIT];
    if (!s_q.strap_done) begin
      s_d.strap_done                = 1'b1;
      s_d.mac[MAC_TX_DIS_BIT]       = flow_control_strap_pin;
      s_d.mac[MAC_RX_DIS_BIT]       = flow_control_strap_pin;
      s_d.mac[MAC_AGE_EN_BIT]       = aging_strap_pin;
      s_d.mac[MAC_BACKOFF_BIT]      = backoff_strap_pin;
    end else if (rif.wr_en) begin
      if (rif.idx == FWD_POL_IDX) begin
        s_d.fwd = rif.wdata & FWD_POL_MASK;
      end else if (rif.idx == MAC_POL_IDX) begin
        s_d.mac = rif.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{fwd: FWD_POL_RST, mac: MAC_POL_RST, strap_done: 1'b0,
               link_prev: '0, tx_fc: '0, rx_fc: '0,
               res_valid: 1'b0, drop: 1'b0, flush: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // aging timer
  // ----------------------------------------------------------------
  sgpc_age_timer #(
    .CNT_W      (AGE_CNT_W),
    .NORMAL_CYC (AGE_NORMAL_CYC),
    .FAST_CYC   (FAST_AGE_CYC)
  ) u_age (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .age_en      (s_q.mac[MAC_AGE_EN_BIT]),
    .fast_age    (s_q.mac[MAC_FAST_BIT]),
    .trigger     (fast_trig_w),
    .age_tick    (age_tick),
    .fast_active (fast_age_active)
  );

  assign rx_result_valid    = s_q.res_valid;
  assign rx_drop            = s_q.drop;
  assign tx_fc_en           = s_q.tx_fc;
  assign rx_fc_en           = s_q.rx_fc;
  assign aggressive_backoff = s_q.mac[MAC_BACKOFF_BIT];
  assign pass_all_frames    = s_q.mac[MAC_PASS_BIT];
  assign table_flush        = s_q.flush;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_fc_loose;
    @(posedge core_clk) disable iff (!resetn)
    (rx_valid && s_q.fwd[FWD_FC_SEL_BIT] && !s_q.mac[MAC_PASS_BIT] &&
     (rx_type_len == PAUSE_TYPE || rx_da == PAUSE_DA)) |=> (rx_result_valid && rx_drop);
  endproperty
  a_fc_loose: assert property (p_fc_loose) else $error("control frame not dropped");

  property p_fc_strict;
    @(posedge core_clk) disable iff (!resetn)
    (rx_valid && !s_q.fwd[FWD_FC_SEL_BIT] && !rx_is_pause && !rx_bad &&
     !s_q.mac[MAC_LEN_CHK_BIT]) |=> (rx_result_valid && !rx_drop);
  endproperty
  a_fc_strict: assert property (p_fc_strict) else $error("non-pause frame dropped");

  property p_link_fast;
    @(posedge core_clk) disable iff (!resetn)
    (s_q.strap_done && any_fall_w && s_q.fwd[FWD_LNK_AGE_BIT] && s_q.mac[MAC_AGE_EN_BIT])
    |=> fast_age_active;
  endproperty
  a_link_fast: assert property (p_link_fast) else $error("link loss gave no fast aging");

  property p_flush;
    @(posedge core_clk) disable iff (!resetn)
    (any_fall_w && s_q.mac[MAC_AGE_EN_BIT]) |=>
      table_flush ##1 (table_flush == $past(any_fall_w && s_q.mac[MAC_AGE_EN_BIT]));
  endproperty
  a_flush: assert property (p_flush) else $error("table flush missing");

  property p_pass_all;
    @(posedge core_clk) disable iff (!resetn)
    (rx_valid && s_q.mac[MAC_PASS_BIT]) |=> (rx_result_valid && !rx_drop);
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("frame dropped in pass-all");

  property p_tx_fc;
    @(posedge core_clk) disable iff (!resetn)
    s_q.mac[MAC_TX_DIS_BIT] ##1 s_q.mac[MAC_TX_DIS_BIT] |-> (tx_fc_en == '0);
  endproperty
  a_tx_fc: assert property (p_tx_fc) else $error("tx pause enabled while disabled");

  property p_rx_fc;
    @(posedge core_clk) disable iff (!resetn)
    !s_q.mac[MAC_RX_DIS_BIT] |=> (rx_fc_en == $past(an_rx_pause));
  endproperty
  a_rx_fc: assert property (p_rx_fc) else $error("rx pause not following result");

  property p_fc_strap;
    @(posedge core_clk) disable iff (!resetn)
    $rose(s_q.strap_done) |-> (s_q.mac[MAC_TX_DIS_BIT] == $past(flow_control_strap_pin) &&
                               s_q.mac[MAC_RX_DIS_BIT] == $past(flow_control_strap_pin));
  endproperty
  a_fc_strap: assert property (p_fc_strap) else $error("pause defaults not strapped");

  property p_len_chk;
    @(posedge core_clk) disable iff (!resetn)
    (rx_valid && s_q.mac[MAC_LEN_CHK_BIT] && !s_q.mac[MAC_PASS_BIT] &&
     rx_type_len < LEN_LIMIT && rx_type_len != rx_len) |=> rx_drop;
  endproperty
  a_len_chk: assert property (p_len_chk) else $error("length mismatch not dropped");

  property p_age_off;
    @(posedge core_clk) disable iff (!resetn)
    (!s_q.mac[MAC_AGE_EN_BIT] && s_q.strap_done) [*2] |-> (!age_tick && !table_flush);
  endproperty
  a_age_off: assert property (p_age_off) else $error("aging while disabled");

  property p_age_strap;
    @(posedge core_clk) disable iff (!resetn)
    $rose(s_q.strap_done) |-> (s_q.mac[MAC_AGE_EN_BIT] == $past(aging_strap_pin));
  endproperty
  a_age_strap: assert property (p_age_strap) else $error("aging default not strapped");

  property p_backoff;
    @(posedge core_clk) disable iff (!resetn)
    $rose(s_q.strap_done) |-> (aggressive_backoff == $past(backoff_strap_pin));
  endproperty
  a_backoff: assert property (p_backoff) else $error("back-off default not strapped");

  property p_sw_write;
    @(posedge core_clk) disable iff (!resetn)
    (s_q.strap_done && rif.wr_en && rif.idx == MAC_POL_IDX) |=>
      (s_q.mac == $past(rif.wdata) ##1 s_q.strap_done);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("write did not take effect");

  // ----------------------------------------------------------------
  // bus checks
  // ----------------------------------------------------------------
  property p_apb_ready;
    @(posedge core_clk) disable iff (!resetn)
    (psel && !penable && !pready) |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("setup not answered");

  property p_apb_once;
    @(posedge core_clk) disable iff (!resetn)
    pready |=> !pready;
  endproperty
  a_apb_once: assert property (p_apb_once) else $error("ready held too long");

  // unmapped or misaligned: error, zero data, nothing written
  property p_apb_err;
    @(posedge core_clk) disable iff (!resetn)
    (psel && !penable && !pready && !(rif.hit && paddr[1:0] == 2'h0)) |=>
      (pready && pslverr && prdata == 32'h0);
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("bad address not refused");

  property p_rd_mac;
    @(posedge core_clk) disable iff (!resetn)
    (psel && !penable && !pwrite && !pready && paddr == {MAC_POL_IDX, 2'h0}) |=>
      (prdata == {24'h0, $past(s_q.mac)});
  endproperty
  a_rd_mac: assert property (p_rd_mac) else $error("mac policy read wrong");

  property p_fwd_wr;
    @(posedge core_clk) disable iff (!resetn)
    (s_q.strap_done && rif.wr_en && rif.idx == FWD_POL_IDX) |=>
      (s_q.fwd == ($past(rif.wdata) & FWD_POL_MASK));
  endproperty
  a_fwd_wr: assert property (p_fwd_wr) else $error("forwarding write lost");

  // ----------------------------------------------------------------
  // pause, frame and aging checks
  // ----------------------------------------------------------------
  property p_tx_on;
    @(posedge core_clk) disable iff (!resetn)
    !s_q.mac[MAC_TX_DIS_BIT] |=> (tx_fc_en == $past(an_tx_pause));
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx pause not following result");

  property p_rx_off;
    @(posedge core_clk) disable iff (!resetn)
    s_q.mac[MAC_RX_DIS_BIT] |=> (rx_fc_en == '0);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx pause on while disabled");

  property p_pause_drop;
    @(posedge core_clk) disable iff (!resetn)
    (rx_valid && !s_q.fwd[FWD_FC_SEL_BIT] && rx_is_pause &&
     !s_q.mac[MAC_PASS_BIT]) |=> rx_drop;
  endproperty
  a_pause_drop: assert property (p_pause_drop) else $error("pause frame kept");

  property p_bad_drop;
    @(posedge core_clk) disable iff (!resetn)
    (rx_valid && rx_bad && !s_q.mac[MAC_PASS_BIT]) |=> rx_drop;
  endproperty
  a_bad_drop: assert property (p_bad_drop) else $error("errored frame kept");

  // a result only ever answers a frame of the cycle before
  property p_no_frame;
    @(posedge core_clk) disable iff (!resetn)
    !rx_valid |=> (!rx_result_valid && !rx_drop);
  endproperty
  a_no_frame: assert property (p_no_frame) else $error("result without a frame");

  property p_fast_end;
    @(posedge core_clk) disable iff (!resetn)
    ($fell(fast_age_active) && $past(s_q.mac[MAC_AGE_EN_BIT])) |-> age_tick;
  endproperty
  a_fast_end: assert property (p_fast_end) else $error("fast pass ended without tick");

endmodule : sgpc_global_policy_ctrl

// file: core/sgpc_pkg.sv
package sgpc_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned APB_AW       = 12;
  localparam int unsigned IDX_W        = APB_AW - 2;
  localparam int unsigned REG_W        = 8;
  localparam logic [IDX_W-1:0] FWD_POL_IDX = 10'h002;
  localparam logic [IDX_W-1:0] MAC_POL_IDX = 10'h003;
  localparam logic [REG_W-1:0] FWD_POL_RST  = 8'h00;
  localparam logic [REG_W-1:0] FWD_POL_MASK = 8'h03;
  localparam logic [REG_W-1:0] MAC_POL_RST  = 8'h04;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned FWD_FC_SEL_BIT  = 1;
  localparam int unsigned FWD_LNK_AGE_BIT = 0;
  localparam int unsigned MAC_PASS_BIT    = 7;
  localparam int unsigned MAC_TX_DIS_BIT  = 5;
  localparam int unsigned MAC_RX_DIS_BIT  = 4;
  localparam int unsigned MAC_LEN_CHK_BIT = 3;
  localparam int unsigned MAC_AGE_EN_BIT  = 2;
  localparam int unsigned MAC_FAST_BIT    = 1;
  localparam int unsigned MAC_BACKOFF_BIT = 0;

  // ----------------------------------------------------------------
  // frame matching
  // ----------------------------------------------------------------
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  localparam logic [47:0] PAUSE_DA   = 48'h0180C2000001;
  localparam logic [15:0] LEN_LIMIT  = 16'h05DC;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ       = 64'd100000000;
  localparam longint unsigned AGE_NORMAL_S = 64'd300;
  localparam longint unsigned AGE_SLACK_S  = 64'd75;
  localparam longint unsigned FAST_AGE_US  = 64'd800;
  localparam longint unsigned AGE_NORMAL_CYC_DFLT = (AGE_NORMAL_S + AGE_SLACK_S) * CLK_HZ;
  localparam longint unsigned FAST_AGE_CYC_DFLT   = (FAST_AGE_US * CLK_HZ) / 64'd1000000;
  localparam int unsigned     AGE_CNT_W           = 36;

  // ----------------------------------------------------------------
  // bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    APB_IDLE   = 2'h1,
    APB_ACCESS = 2'h2
  } sgpc_apb_st_e;

endpackage : sgpc_pkg

// file: core/sgpc_reg_if.sv
`timescale 1ns/1ns
interface sgpc_reg_if;
  import sgpc_pkg::*;
  logic             wr_en;
  logic [IDX_W-1:0] idx;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] rdata;
  logic             hit;

  modport bus  (output wr_en, output idx, output wdata, input rdata, input hit);
  modport regs (input wr_en, input idx, input wdata, output rdata, output hit);
endinterface : sgpc_reg_if

// file: test/sgpc_global_policy_ctrl_tb_top.sv
`timescale 1ns/1ns
module sgpc_global_policy_ctrl_tb_top
  import sgpc_pkg::*;
();
  // ------
  // small aging counts keep the run short
  // ------
  localparam int NP   = 5;
  localparam int FAST = 20;
  localparam int NORM = 200;
  logic              core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, w;
  logic              fc_s, age_s, bo_s, rx_valid, rx_is_pause, rx_bad, res_v, rx_drop;
  logic [NP-1:0]     link_up, an_tx, an_rx, tx_fc_en, rx_fc_en;
  logic [15:0]       rx_type_len, rx_len;
  logic [47:0]       rx_da;
  logic              backoff, pass_all, age_tick, fast_act, flush;
  logic [32:0]       exp_q[$];
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                n;

  sgpc_global_policy_ctrl #(.NPORTS(NP), .AGE_NORMAL_CYC(NORM), .FAST_AGE_CYC(FAST))
    u_sgpc_global_policy_ctrl (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flow_control_strap_pin(fc_s),
    .aging_strap_pin(age_s), .backoff_strap_pin(bo_s), .port_link_up(link_up),
    .an_tx_pause(an_tx), .an_rx_pause(an_rx), .rx_valid(rx_valid),
    .rx_type_len(rx_type_len), .rx_da(rx_da), .rx_len(rx_len), .rx_is_pause(rx_is_pause),
    .rx_bad(rx_bad), .rx_result_valid(res_v), .rx_drop(rx_drop), .tx_fc_en(tx_fc_en),
    .rx_fc_en(rx_fc_en), .aggressive_backoff(backoff), .pass_all_frames(pass_all),
    .age_tick(age_tick), .fast_age_active(fast_act), .table_flush(flush));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ------
  // shared tasks
  // ------
  task automatic complete_run();
    // an answer that never came leaves its note behind
    if (exp_q.size() != 0) n_mismatch++;
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // no wait-state count assumed, only a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int k;
    exp_q.push_back(e);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    // pready read mid-cycle; the handover is the next rising edge
    do begin
      @(negedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    @(posedge core_clk);
    if (k >= 64) n_mismatch++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, {25'h0, e});
  endtask : rd

  // leaves rx_valid high so frames run back to back
  task automatic frame(input logic sel, input logic lchk, input logic pass);
    logic [15:0] t, l;
    logic [47:0] da;
    logic        pz, bd;
    l = 16'($urandom_range(1600));
    case ($urandom_range(3))
      0: t = 16'h8808;
      1: t = 16'($urandom);
      2: t = 16'($urandom_range(1600));
      default: t = l;
    endcase
    da = $urandom_range(1) ? 48'h0180C2000001 : {16'($urandom), 32'($urandom)};
    pz = 1'($urandom);
    bd = ($urandom_range(7) == 0);
    exp_q.push_back({32'h0, !pass & ((sel ? (t == 16'h8808 || da == 48'h0180C2000001) : pz)
                     | (lchk && t < 16'd1500 && t != l) | bd)});
    @(posedge core_clk);
    rx_valid    <= 1'b1;
    rx_type_len <= t;
    rx_len      <= l;
    rx_da       <= da;
    rx_is_pause <= pz;
    rx_bad      <= bd;
  endtask : frame

  task automatic until_hi(input int s, output int k);
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while ((s ? age_tick : flush) !== 1'b1 && k < 400);
    @(posedge core_clk);
  endtask : until_hi

  // outputs are read mid-cycle, where they stand settled
  always @(negedge core_clk) begin
    if (pready === 1'b1 || res_v === 1'b1) begin
      if (exp_q.size() == 0) exp_q.push_back(33'h1FFFFFFFF);
      chk(res_v === 1'b1 ? {32'h0, rx_drop} : {pslverr, pwrite ? 32'h0 : prdata},
          exp_q.pop_front());
    end
  end

  initial begin
    #(10 * 40000);
    n_mismatch++;
    complete_run();
  end

  // ------
  // main sequence
  // ------
  initial begin
    void'($urandom(51030));
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_valid, rx_type_len, rx_len, rx_da, rx_is_pause, rx_bad, an_tx, an_rx} = '0;
    fc_s    = 1'($urandom);
    age_s   = 1'($urandom);
    bo_s    = 1'($urandom);
    link_up = '1;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    rd(12'h008, 8'h00);
    rd(12'h00C, {2'b00, fc_s, fc_s, 1'b0, age_s, 1'b0, bo_s});
    chk(backoff, bo_s);
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      wr(12'h008, w);
      rd(12'h008, w[7:0] & 8'h03);
      wr(12'h00C, w ^ 32'h5A);
      rd(12'h00C, w[7:0] ^ 8'h5A);
    end
    apb(1'b1, 12'h009, 32'hFF, 33'h100000000);
    apb(1'b0, 12'h010, 32'h0, 33'h100000000);
    apb(1'b1, 12'h004, 32'hFF, 33'h100000000);
    rd(12'h008, w[7:0] & 8'h03);
    for (int c = 0; c < 8; c++) begin
      wr(12'h008, {c[0], 1'b0});
      wr(12'h00C, {c[2], 3'b000, c[1], 3'b000});
      repeat (3) @(posedge core_clk);
      chk(pass_all, c[2]);
      repeat (8) frame(c[0], c[1], c[2]);
      @(posedge core_clk);
      rx_valid <= 1'b0;
    end
    for (int c = 0; c < 4; c++) begin
      an_tx <= NP'($urandom);
      an_rx <= NP'($urandom);
      wr(12'h00C, {2'b00, c[1], c[0], 3'b010, c[0]});
      repeat (3) @(posedge core_clk);
      chk(tx_fc_en, an_tx & {NP{!c[1]}});
      chk(rx_fc_en, an_rx & {NP{!c[0]}});
      chk(backoff, c[0]);
    end
    // link loss without, then with, the fast pass
    for (int f = 0; f < 2; f++) begin
      wr(12'h008, f);
      link_up[2 + f] <= 1'b0;
      until_hi(0, n);
      chk(33'(n >= 1 && n <= 3), 33'h1);
      chk(fast_act, f[0]);
      if (f == 1) begin
        until_hi(1, n);
        chk(33'(n >= FAST - 2 && n <= FAST + 1), 33'h1);
        chk(fast_act, 1'b0);
        until_hi(1, n);
        chk(33'(n >= NORM - 1 && n <= NORM + 1), 33'h1);
      end
      link_up <= '1;
    end
    wr(12'h00C, 32'h06);
    until_hi(1, n);
    until_hi(1, n);
    chk(33'(n >= FAST - 1 && n <= FAST + 1), 33'h1);
    wr(12'h00C, 32'h00);
    link_up[1] <= 1'b0;
    until_hi(0, n);
    chk(33'(n), 33'd400);
    until_hi(1, n);
    chk(33'(n), 33'd400);
    complete_run();
  end
endmodule : sgpc_global_policy_ctrl_tb_top
